// File: ppom_regs.svh
`ifndef PPOM_REGS_SVH
`define PPOM_REGS_SVH

// Register bus geometry
`define PPOM_ADDR_W 4
`define PPOM_DATA_W 8

// Register offsets
`define PPOM_OFS_DIR 4'h0
`define PPOM_OFS_OUT 4'h1
`define PPOM_OFS_IN 4'h2
`define PPOM_OFS_MCU 4'h3

// Control register fields
`define PPOM_MCU_PUD_BIT 6
`define PPOM_MCU_SE_BIT 5
`define PPOM_MCU_SM_HI 4
`define PPOM_MCU_SM_LO 3
`define PPOM_MCU_WR_MASK 8'h78
`define PPOM_MCU_RESET 8'h00

// Port register reset values
`define PPOM_DIR_RESET 8'h00
`define PPOM_OUT_RESET 8'h00

// Pin carrying the shared clock, timer and interrupt functions
`define PPOM_SHARED_PIN 2

// Synchroniser depth on the pad input
`define PPOM_SYNC_STAGES 2

`endif

// File: ppom_pkg.sv
package ppom_pkg;

    typedef logic [7:0] ppom_byte_t;

    typedef enum logic [2:0] {
        PPOM_SEL_NONE = 3'h0,
        PPOM_SEL_DIR = 3'h1,
        PPOM_SEL_OUT = 3'h2,
        PPOM_SEL_IN = 3'h3,
        PPOM_SEL_MCU = 3'h4
    } ppom_sel_e;

endpackage : ppom_pkg

// File: ppom_sync.sv
`timescale 1ns/1ps
`include "ppom_regs.svh"

module ppom_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);

    logic [`PPOM_SYNC_STAGES-1:0] stage;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage <= '0;
        end else begin
            stage <= {stage[`PPOM_SYNC_STAGES-2:0], async_in};
        end
    end

    assign sync_out = stage[`PPOM_SYNC_STAGES-1];

endmodule : ppom_sync

// File: ppom_pin.sv
`timescale 1ns/1ps

module ppom_pin (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Software and global controls
    input wire logic pin_direction_bit,
    input wire logic pin_output_bit,
    input wire logic global_pullup_disable,
    input wire logic sleep_clamp,
    // Alternate-function overrides
    input wire logic pullup_override_en,
    input wire logic pullup_override_val,
    input wire logic dir_override_en,
    input wire logic dir_override_val,
    input wire logic value_override_en,
    input wire logic value_override_val,
    input wire logic input_en_override_en,
    input wire logic input_en_override_val,
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pullup_en,
    output logic pad_input_en,
    // Input paths
    output logic alt_digital_in,
    output logic pin_sync_in
);

    wire plain_pullup = ~pin_direction_bit & pin_output_bit & ~global_pullup_disable; // RULE2 RULE17
    wire sel_pullup = pullup_override_en ? pullup_override_val : plain_pullup; // RULE1 RULE3
    wire sel_oe = dir_override_en ? dir_override_val : pin_direction_bit; // RULE4 RULE5 RULE6
    wire sel_val = value_override_en ? value_override_val : pin_output_bit; // RULE7 RULE8 RULE9
    wire sel_ie = input_en_override_en ? input_en_override_val : ~sleep_clamp; // RULE11 RULE12 RULE13

    // Reset releases the pad at once, clock or not
    assign pad_oe = rst_n & sel_oe; // RULE23
    assign pad_pullup_en = rst_n & sel_pullup;
    assign pad_out = sel_val;
    assign pad_input_en = sel_ie;
    // Clamp to ground when input disabled; tap before sync
    assign alt_digital_in = pad_in & sel_ie; // RULE14

    ppom_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(alt_digital_in),
        .sync_out(pin_sync_in)
    );

endmodule : ppom_pin

// File: ppom_port.sv
// Contract
// RULE1: Pull-up override enable makes pull-up follow only the override value.
// RULE2: Without override, pull-up on only for input, output bit one, no global disable.
// RULE3: Under pull-up override, value one enables and zero disables the pull-up.
// RULE4: Direction override enable hands driver enable to the direction override value.
// RULE5: Without direction override, driver enabled exactly when direction bit is one.
// RULE6: Under direction override, value one enables and zero disables the driver.
// RULE7: Value override with driver on drives the value override signal.
// RULE8: Without value override, driven level equals the software output bit.
// RULE9: Under value override, software output bit is ignored for the driven level.
// RULE10: Toggle override enable inverts the stored software output bit.
// RULE11: Input-enable override takes input enable from the override value.
// RULE12: Without that override, input enable is on unless sleep clamps it.
// RULE13: Under input-enable override, value decides input enable regardless of sleep.
// RULE14: Alternate digital input is tapped after clamp, before the two-stage synchroniser.
// RULE15: Consumers of the raw digital input synchronise it unless used as clock.
// RULE16: Analog path connects straight to the pad, both directions, no gating.
// RULE17: Global pull-up disable bit 6 turns all pull-ups off; here a pin under pull-up override keeps the override value.
// RULE18: Control register bits 7 and 2 always read zero.
// RULE19: Alternate-function modules generate their own override enables and values.
// RULE20: Strobes shared per port, clock/sleep/disable shared, overrides per pin.
// RULE21: Pin 2 carries serial clock, analog channel one, timer, interrupt, pin change.
// RULE22: Writing one to an input register bit inverts that pin's output bit.
// RULE23: Direction one means output; pins are tri-stated while reset is active.
// RULE24: Override multiplexing is combinational, no added clock cycle.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ppom_regs.svh"

module ppom_port #(
    parameter int NPINS = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`PPOM_ADDR_W-1:0] reg_addr,
    input wire logic [`PPOM_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PPOM_DATA_W-1:0] reg_rdata,
    // Sleep controller
    input wire logic sleep_clamp,
    output logic sleep_enable,
    output logic [1:0] sleep_mode,
    // Pads
    input wire logic [NPINS-1:0] pad_in,
    output logic [NPINS-1:0] pad_out,
    output logic [NPINS-1:0] pad_oe,
    output logic [NPINS-1:0] pad_pullup_en,
    output logic [NPINS-1:0] pad_input_en,
    // Analog pad path
    input wire logic [NPINS-1:0] pad_analog_in,
    output logic [NPINS-1:0] pad_analog_out,
    output logic [NPINS-1:0] pad_analog_oe,
    input wire logic [NPINS-1:0] alt_analog_out,
    input wire logic [NPINS-1:0] alt_analog_oe,
    output logic [NPINS-1:0] analog_pad_io,
    // Overrides from alternate-function modules
    input wire logic [NPINS-1:0] pullup_override_en,
    input wire logic [NPINS-1:0] pullup_override_val,
    input wire logic [NPINS-1:0] dir_override_en,
    input wire logic [NPINS-1:0] dir_override_val,
    input wire logic [NPINS-1:0] value_override_en,
    input wire logic [NPINS-1:0] value_override_val,
    input wire logic [NPINS-1:0] toggle_override_en,
    input wire logic [NPINS-1:0] input_en_override_en,
    input wire logic [NPINS-1:0] input_en_override_val,
    // Digital inputs to alternate-function modules
    output logic [NPINS-1:0] alt_digital_in,
    // Shared pin functions
    output logic timer_zero_count_in,
    output logic serial_iface_clk,
    output logic ext_irq_zero_in,
    output logic pin_change_src_two,
    output logic analog_channel_one
);

    if (NPINS <= `PPOM_SHARED_PIN || NPINS > `PPOM_DATA_W) begin : g_bad_npins
        $error("NPINS must be between 3 and 8");
    end

    localparam int PAD = `PPOM_DATA_W - NPINS;

    logic [NPINS-1:0] pin_direction_bit;
    logic [NPINS-1:0] pin_output_bit;
    logic [NPINS-1:0] pin_input_bit;
    logic [`PPOM_DATA_W-1:0] mcu_control;

    // Address decode
    wire hit_dir = reg_addr == `PPOM_OFS_DIR;
    wire hit_out = reg_addr == `PPOM_OFS_OUT;
    wire hit_in = reg_addr == `PPOM_OFS_IN;
    wire hit_mcu = reg_addr == `PPOM_OFS_MCU;
    wire wr_dir = reg_wr & hit_dir;
    wire wr_out = reg_wr & hit_out;
    wire wr_in = reg_wr & hit_in;
    wire wr_mcu = reg_wr & hit_mcu;
    wire global_pullup_disable = mcu_control[`PPOM_MCU_PUD_BIT];

    ppom_pkg::ppom_sel_e rd_sel;
    assign rd_sel = hit_dir ? ppom_pkg::PPOM_SEL_DIR :
                    hit_out ? ppom_pkg::PPOM_SEL_OUT :
                    hit_in ? ppom_pkg::PPOM_SEL_IN :
                    hit_mcu ? ppom_pkg::PPOM_SEL_MCU : ppom_pkg::PPOM_SEL_NONE;

    ppom_pkg::ppom_byte_t rd_mux;
    always_comb begin
        case (rd_sel)
            ppom_pkg::PPOM_SEL_DIR: rd_mux = {{PAD{1'b0}}, pin_direction_bit};
            ppom_pkg::PPOM_SEL_OUT: rd_mux = {{PAD{1'b0}}, pin_output_bit};
            ppom_pkg::PPOM_SEL_IN: rd_mux = {{PAD{1'b0}}, pin_input_bit};
            ppom_pkg::PPOM_SEL_MCU: rd_mux = mcu_control & `PPOM_MCU_WR_MASK; // RULE18
            default: rd_mux = 8'h00;
        endcase
    end

    // Output bit: write, toggle by input register, toggle override
    wire [NPINS-1:0] wdata_pins = reg_wdata[NPINS-1:0];
    wire [NPINS-1:0] base_out = wr_out ? wdata_pins : pin_output_bit;
    wire [NPINS-1:0] sw_toggle = wr_in ? wdata_pins : '0; // RULE22
    wire [NPINS-1:0] next_output_bit = base_out ^ sw_toggle ^ toggle_override_en; // RULE10
    wire [NPINS-1:0] next_direction_bit = wr_dir ? wdata_pins : pin_direction_bit;
    wire [`PPOM_DATA_W-1:0] next_mcu_control = wr_mcu ? (reg_wdata & `PPOM_MCU_WR_MASK) : mcu_control; // RULE17

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_direction_bit <= NPINS'(`PPOM_DIR_RESET); // RULE23
            pin_output_bit <= NPINS'(`PPOM_OUT_RESET);
            mcu_control <= `PPOM_MCU_RESET;
        end else begin
            pin_direction_bit <= next_direction_bit;
            pin_output_bit <= next_output_bit;
            mcu_control <= next_mcu_control;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            sleep_enable <= 1'b0;
            sleep_mode <= 2'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            sleep_enable <= next_mcu_control[`PPOM_MCU_SE_BIT];
            sleep_mode <= next_mcu_control[`PPOM_MCU_SM_HI:`PPOM_MCU_SM_LO];
        end
    end

    // One mux slice per pin; strobes and globals fan out to all
    for (genvar k = 0; k < NPINS; k++) begin : g_pin // RULE20
        ppom_pin u_pin (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .pin_direction_bit(pin_direction_bit[k]),
            .pin_output_bit(pin_output_bit[k]),
            .global_pullup_disable(global_pullup_disable),
            .sleep_clamp(sleep_clamp),
            .pullup_override_en(pullup_override_en[k]),
            .pullup_override_val(pullup_override_val[k]),
            .dir_override_en(dir_override_en[k]),
            .dir_override_val(dir_override_val[k]),
            .value_override_en(value_override_en[k]),
            .value_override_val(value_override_val[k]),
            .input_en_override_en(input_en_override_en[k]),
            .input_en_override_val(input_en_override_val[k]),
            .pad_in(pad_in[k]),
            .pad_out(pad_out[k]),
            .pad_oe(pad_oe[k]),
            .pad_pullup_en(pad_pullup_en[k]),
            .pad_input_en(pad_input_en[k]),
            .alt_digital_in(alt_digital_in[k]),
            .pin_sync_in(pin_input_bit[k])
        ); // RULE24
    end

    // Analog path straight through, no gating
    assign analog_pad_io = pad_analog_in; // RULE16
    assign pad_analog_out = alt_analog_out;
    assign pad_analog_oe = alt_analog_oe;

    // Shared pin fan-out; consumers synchronise themselves
    assign timer_zero_count_in = alt_digital_in[`PPOM_SHARED_PIN]; // RULE21 RULE15
    assign serial_iface_clk = alt_digital_in[`PPOM_SHARED_PIN];
    assign ext_irq_zero_in = alt_digital_in[`PPOM_SHARED_PIN];
    assign pin_change_src_two = alt_digital_in[`PPOM_SHARED_PIN];
    assign analog_channel_one = pad_analog_in[`PPOM_SHARED_PIN];

    // Checks
    wire [NPINS-1:0] no_pu_ovr = ~pullup_override_en;
    wire [NPINS-1:0] no_dir_ovr = ~dir_override_en;
    wire [NPINS-1:0] val_ovr_on = value_override_en & pad_oe;
    wire [NPINS-1:0] val_ovr_off = ~value_override_en & pad_oe;
    wire [NPINS-1:0] plain_pu = ~pin_direction_bit & pin_output_bit & {NPINS{~global_pullup_disable}};

    property p_pullup_override;
        @(posedge core_clk) disable iff (!rst_n)
        (pad_pullup_en & pullup_override_en) == (pullup_override_val & pullup_override_en);
    endproperty
    a_pullup_override: assert property (p_pullup_override) else $error("pull-up ignores override"); // RULE1 RULE3

    property p_pullup_plain;
        @(posedge core_clk) disable iff (!rst_n)
        (pad_pullup_en & no_pu_ovr) == (plain_pu & no_pu_ovr);
    endproperty
    a_pullup_plain: assert property (p_pullup_plain) else $error("pull-up wrong without override"); // RULE2

    property p_pud_kills;
        @(posedge core_clk) disable iff (!rst_n)
        wr_mcu && reg_wdata[`PPOM_MCU_PUD_BIT] |=> (pad_pullup_en & no_pu_ovr) == '0;
    endproperty
    a_pud_kills: assert property (p_pud_kills) else $error("pull-up survives global disable"); // RULE17

    property p_dir_override;
        @(posedge core_clk) disable iff (!rst_n)
        (pad_oe & dir_override_en) == (dir_override_val & dir_override_en);
    endproperty
    a_dir_override: assert property (p_dir_override) else $error("driver ignores override"); // RULE4 RULE6

    property p_dir_plain;
        @(posedge core_clk) disable iff (!rst_n)
        wr_dir |=> (pad_oe & no_dir_ovr) == ($past(wdata_pins) & no_dir_ovr);
    endproperty
    a_dir_plain: assert property (p_dir_plain) else $error("driver does not follow direction write"); // RULE5

    property p_val_override;
        @(posedge core_clk) disable iff (!rst_n)
        (pad_out & val_ovr_on) == (value_override_val & val_ovr_on);
    endproperty
    a_val_override: assert property (p_val_override) else $error("driven value ignores override"); // RULE7 RULE9

    property p_val_plain;
        @(posedge core_clk) disable iff (!rst_n)
        (pad_out & val_ovr_off) == (pin_output_bit & val_ovr_off);
    endproperty
    a_val_plain: assert property (p_val_plain) else $error("driven value not output bit"); // RULE8

    sequence s_quiet_out;
        !wr_out && !wr_in;
    endsequence

    property p_toggle_override;
        @(posedge core_clk) disable iff (!rst_n)
        s_quiet_out |=> pin_output_bit == ($past(pin_output_bit) ^ $past(toggle_override_en));
    endproperty
    a_toggle_override: assert property (p_toggle_override) else $error("toggle override lost"); // RULE10

    property p_sw_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        wr_in && toggle_override_en == '0 |=> pin_output_bit == ($past(pin_output_bit) ^ $past(wdata_pins));
    endproperty
    a_sw_toggle: assert property (p_sw_toggle) else $error("input register write did not toggle"); // RULE22

    property p_input_en;
        @(posedge core_clk) disable iff (!rst_n)
        pad_input_en == ((input_en_override_en & input_en_override_val)
                        | (~input_en_override_en & {NPINS{~sleep_clamp}}));
    endproperty
    a_input_en: assert property (p_input_en) else $error("input enable wrong"); // RULE11 RULE12 RULE13

    property p_sync_delay;
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n, 3) |-> pin_input_bit == $past(alt_digital_in, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("input register not two stages behind"); // RULE14

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && hit_mcu |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bits read nonzero"); // RULE18

    // Pads released while reset is low, whatever the overrides say
    property p_rst_tristate;
        @(posedge core_clk)
        !rst_n |-> pad_oe == '0 && pad_pullup_en == '0;
    endproperty
    a_rst_tristate: assert property (p_rst_tristate) else $error("pad driven in reset"); // RULE23

    property p_dir_level;
        @(posedge core_clk) disable iff (!rst_n)
        (pad_oe & no_dir_ovr) == (pin_direction_bit & no_dir_ovr);
    endproperty
    a_dir_level: assert property (p_dir_level) else $error("driver not direction bit"); // RULE5

    property p_pud_level;
        @(posedge core_clk) disable iff (!rst_n)
        global_pullup_disable |-> (pad_pullup_en & no_pu_ovr) == '0;
    endproperty
    a_pud_level: assert property (p_pud_level) else $error("pull-up on under global disable"); // RULE17

    property p_alt_in;
        @(posedge core_clk) disable iff (!rst_n)
        alt_digital_in == (pad_in & pad_input_en);
    endproperty
    a_alt_in: assert property (p_alt_in) else $error("raw input not gated pad level"); // RULE14

    property p_analog_path;
        @(posedge core_clk) disable iff (!rst_n)
        analog_pad_io == pad_analog_in && pad_analog_out == alt_analog_out && pad_analog_oe == alt_analog_oe;
    endproperty
    a_analog_path: assert property (p_analog_path) else $error("analog path gated"); // RULE16

    property p_shared_pin;
        @(posedge core_clk) disable iff (!rst_n)
        {timer_zero_count_in, serial_iface_clk, ext_irq_zero_in, pin_change_src_two}
            == {4{alt_digital_in[`PPOM_SHARED_PIN]}}
        && analog_channel_one == pad_analog_in[`PPOM_SHARED_PIN];
    endproperty
    a_shared_pin: assert property (p_shared_pin) else $error("shared pin fan-out wrong"); // RULE21

    // Read data stand one cycle only
    property p_rdata_idle;
        @(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    property p_unmapped_zero;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && rd_sel == ppom_pkg::PPOM_SEL_NONE |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

endmodule : ppom_port

// File: ppom_alt_model.sv
`timescale 1ns/1ps

module ppom_alt_model #(
    parameter int NPINS = 6
) (
    // Clock
    input wire logic core_clk,
    // Raw digital input from the port
    input wire logic [NPINS-1:0] alt_digital_in,
    // Overrides to the port
    output logic [NPINS-1:0] pullup_override_en,
    output logic [NPINS-1:0] pullup_override_val,
    output logic [NPINS-1:0] dir_override_en,
    output logic [NPINS-1:0] dir_override_val,
    output logic [NPINS-1:0] value_override_en,
    output logic [NPINS-1:0] value_override_val,
    output logic [NPINS-1:0] toggle_override_en,
    output logic [NPINS-1:0] input_en_override_en,
    output logic [NPINS-1:0] input_en_override_val,
    // Analog drive toward the pad
    output logic [NPINS-1:0] alt_analog_out,
    output logic [NPINS-1:0] alt_analog_oe,
    // Own synchronised copy of the raw input
    output logic [NPINS-1:0] synced_in
);
    logic [NPINS-1:0] sync_meta;

    initial begin
        {pullup_override_en, pullup_override_val, dir_override_en, dir_override_val} = '0;
        {value_override_en, value_override_val, toggle_override_en} = '0;
        {input_en_override_en, input_en_override_val, alt_analog_out, alt_analog_oe} = '0;
        sync_meta = '0;
        synced_in = '0;
    end

    // Raw input is unsynchronised, so resample it twice here
    always @(posedge core_clk) begin
        sync_meta <= alt_digital_in;
        synced_in <= sync_meta;
    end

    // Drives one override group of one pin just after a clock edge
    task automatic set_ovr(input int kind, input int pin, input logic en, input logic val);
        @(posedge core_clk);
        case (kind)
            0: begin
                pullup_override_en[pin] <= en;
                pullup_override_val[pin] <= val;
            end
            1: begin
                dir_override_en[pin] <= en;
                dir_override_val[pin] <= val;
            end
            2: begin
                value_override_en[pin] <= en;
                value_override_val[pin] <= val;
            end
            3: toggle_override_en[pin] <= en;
            4: begin
                input_en_override_en[pin] <= en;
                input_en_override_val[pin] <= val;
            end
            default: begin
                alt_analog_oe[pin] <= en;
                alt_analog_out[pin] <= val;
            end
        endcase
    endtask : set_ovr
endmodule : ppom_alt_model

// File: ppom_port_tb.sv
`timescale 1ns/1ps
`include "ppom_regs.svh"

module ppom_port_tb;
    localparam int NPINS = 6;
    logic core_clk, rst_n, reg_wr, reg_rd, sleep_clamp;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic sleep_enable, t0_in, sck_in, irq_in, pc_in, an_one;
    logic [1:0] sleep_mode;
    logic [NPINS-1:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_input_en, pad_analog_in;
    logic [NPINS-1:0] pad_analog_out, pad_analog_oe, alt_analog_out, alt_analog_oe, analog_pad_io;
    logic [NPINS-1:0] pu_en, pu_val, dir_en, dir_val, val_en, val_val, tog_en, ie_en, ie_val;
    logic [NPINS-1:0] alt_digital_in, synced_in;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    ppom_port #(.NPINS(NPINS)) dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_clamp(sleep_clamp), .sleep_enable(sleep_enable), .sleep_mode(sleep_mode),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
        .pad_input_en(pad_input_en), .pad_analog_in(pad_analog_in), .pad_analog_out(pad_analog_out),
        .pad_analog_oe(pad_analog_oe), .alt_analog_out(alt_analog_out), .alt_analog_oe(alt_analog_oe),
        .analog_pad_io(analog_pad_io), .pullup_override_en(pu_en), .pullup_override_val(pu_val),
        .dir_override_en(dir_en), .dir_override_val(dir_val), .value_override_en(val_en),
        .value_override_val(val_val), .toggle_override_en(tog_en), .input_en_override_en(ie_en),
        .input_en_override_val(ie_val), .alt_digital_in(alt_digital_in), .timer_zero_count_in(t0_in),
        .serial_iface_clk(sck_in), .ext_irq_zero_in(irq_in), .pin_change_src_two(pc_in),
        .analog_channel_one(an_one));

    ppom_alt_model #(.NPINS(NPINS)) alt (.core_clk(core_clk), .alt_digital_in(alt_digital_in),
        .pullup_override_en(pu_en), .pullup_override_val(pu_val), .dir_override_en(dir_en),
        .dir_override_val(dir_val), .value_override_en(val_en), .value_override_val(val_val),
        .toggle_override_en(tog_en), .input_en_override_en(ie_en), .input_en_override_val(ie_val),
        .alt_analog_out(alt_analog_out), .alt_analog_oe(alt_analog_oe), .synced_in(synced_in));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] addr, input logic [7:0] exp, input string name);
        @(posedge core_clk);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, reg_rdata, exp);
    endtask : rd

    task automatic t_regs();
        rd(`PPOM_OFS_DIR, 8'h00, "dir_reset");
        rd(`PPOM_OFS_OUT, 8'h00, "out_reset");
        rd(`PPOM_OFS_MCU, 8'h00, "mcu_reset");
        wr(`PPOM_OFS_MCU, 8'hFF);
        rd(`PPOM_OFS_MCU, 8'h78, "mcu_reserved");
        chk("sleep_enable", 8'(sleep_enable), 8'h01);
        chk("sleep_mode", 8'(sleep_mode), 8'h03);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00, "unmapped");
        wr(`PPOM_OFS_MCU, 8'h00);
        wr(`PPOM_OFS_DIR, 8'hFF);
        rd(`PPOM_OFS_DIR, 8'h3F, "dir_width");
        wr(`PPOM_OFS_DIR, 8'h00);
    endtask : t_regs

    task automatic t_pullup();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(`PPOM_OFS_DIR, {7'h00, c[2]});
            wr(`PPOM_OFS_OUT, {7'h00, c[1]});
            wr(`PPOM_OFS_MCU, {1'b0, c[0], 6'h00});
            chk("pullup_table", 8'(pad_pullup_en), {7'h00, c == 3'b010});
        end
        wr(`PPOM_OFS_DIR, 8'h00);
        for (int v = 0; v < 2; v++) begin
            alt.set_ovr(0, 0, 1'b1, v[0]);
            #1;
            chk("pullup_override", 8'(pad_pullup_en), {7'h00, v[0]});
        end
        alt.set_ovr(0, 0, 1'b0, 1'b0);
        wr(`PPOM_OFS_MCU, 8'h00);
        chk("pullup_back", 8'(pad_pullup_en), 8'h01);
        wr(`PPOM_OFS_OUT, 8'h00);
    endtask : t_pullup

    task automatic t_drive();
        wr(`PPOM_OFS_DIR, 8'h15);
        chk("oe_dir", 8'(pad_oe), 8'h15);
        alt.set_ovr(1, 1, 1'b1, 1'b1);
        alt.set_ovr(1, 0, 1'b1, 1'b0);
        #1;
        chk("oe_override", 8'(pad_oe), 8'h16);
        alt.set_ovr(1, 1, 1'b0, 1'b0);
        alt.set_ovr(1, 0, 1'b0, 1'b0);
        wr(`PPOM_OFS_DIR, 8'h3F);
        wr(`PPOM_OFS_OUT, 8'h2A);
        chk("out_soft", 8'(pad_out), 8'h2A);
        alt.set_ovr(2, 1, 1'b1, 1'b0);
        alt.set_ovr(2, 0, 1'b1, 1'b1);
        #1;
        chk("out_override", 8'(pad_out), 8'h29);
        alt.set_ovr(2, 1, 1'b0, 1'b0);
        alt.set_ovr(2, 0, 1'b0, 1'b0);
        #1;
        chk("out_restore", 8'(pad_out), 8'h2A);
        wr(`PPOM_OFS_IN, 8'h05);
        rd(`PPOM_OFS_OUT, 8'h2F, "in_write_toggle");
        wr(`PPOM_OFS_DIR, 8'h00);
        wr(`PPOM_OFS_IN, 8'h01);
        rd(`PPOM_OFS_OUT, 8'h2E, "toggle_as_input");
        alt.set_ovr(3, 3, 1'b1, 1'b0);
        alt.set_ovr(3, 3, 1'b0, 1'b0);
        rd(`PPOM_OFS_OUT, 8'h26, "toggle_override");
        wr(`PPOM_OFS_OUT, 8'h00);
    endtask : t_drive

    task automatic t_input();
        @(posedge core_clk);
        pad_in <= 6'h2D;
        sleep_clamp <= 1'b0;
        #1;
        chk("ie_normal", 8'(pad_input_en), 8'h3F);
        chk("alt_in", 8'(alt_digital_in), 8'h2D);
        chk("shared_pin", {4'h0, t0_in, sck_in, irq_in, pc_in}, 8'h0F);
        repeat (3) @(posedge core_clk);
        rd(`PPOM_OFS_IN, 8'h2D, "pin_sync");
        chk("alt_synced", 8'(synced_in), 8'h2D);
        @(posedge core_clk);
        sleep_clamp <= 1'b1;
        #1;
        chk("ie_sleep", 8'(pad_input_en), 8'h00);
        chk("alt_in_sleep", 8'(alt_digital_in), 8'h00);
        alt.set_ovr(4, 2, 1'b1, 1'b1);
        #1;
        chk("ie_override_on", 8'(pad_input_en), 8'h04);
        chk("alt_in_ovr", {4'h0, t0_in, sck_in, irq_in, pc_in}, 8'h0F);
        @(posedge core_clk);
        sleep_clamp <= 1'b0;
        alt.set_ovr(4, 0, 1'b1, 1'b0);
        #1;
        chk("ie_override_off", 8'(pad_input_en), 8'h3E);
        alt.set_ovr(4, 2, 1'b0, 1'b0);
        alt.set_ovr(4, 0, 1'b0, 1'b0);
        pad_analog_in <= 6'h06;
        alt.set_ovr(5, 4, 1'b1, 1'b1);
        #1;
        chk("analog_in", 8'(analog_pad_io), 8'h06);
        chk("analog_ch1", 8'(an_one), 8'h01);
        chk("analog_out", {6'h00, pad_analog_oe[4], pad_analog_out[4]}, 8'h03);
    endtask : t_input

    task automatic print_verdict();
        $display("Checks done %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, sleep_clamp} = 3'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        pad_in = '0;
        pad_analog_in = '0;
        alt.set_ovr(1, 0, 1'b1, 1'b1);
        alt.set_ovr(0, 0, 1'b1, 1'b1);
        repeat (12) @(posedge core_clk);
        #1;
        chk("oe_in_reset", 8'(pad_oe), 8'h00);
        chk("pullup_in_reset", 8'(pad_pullup_en), 8'h00);
        alt.set_ovr(1, 0, 1'b0, 1'b0);
        alt.set_ovr(0, 0, 1'b0, 1'b0);
        rst_n <= 1'b1;
        t_regs();
        t_pullup();
        t_drive();
        t_input();
        print_verdict();
    end
endmodule : ppom_port_tb
